// >>> rtl/spcb_pkg.sv
// constants and state type of the serial client with select and transmit buffer
package spcb_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned IDX_CONTROL_A         = 0;
    localparam int unsigned IDX_CONTROL_B         = 1;
    localparam int unsigned IDX_INTERRUPT_ENABLES = 2;
    localparam int unsigned IDX_INTERRUPT_FLAGS   = 3;
    localparam int unsigned IDX_SERIAL_DATA       = 4;
    localparam int unsigned IDX_LAST              = IDX_SERIAL_DATA;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CA_ENABLE    = 0;
    localparam int unsigned CA_LSB_FIRST = 6;
    localparam int unsigned CB_MODE_LO   = 0;
    localparam int unsigned CB_WAIT_RCV  = 6;
    localparam int unsigned CB_BUF_ON    = 7;
    localparam int unsigned EN_SINGLE    = 0;
    localparam int unsigned FL_XFER      = 7;
    localparam int unsigned FL_WRCOLL    = 6;
    localparam int unsigned FL_RCV_DONE  = 7;
    localparam int unsigned FL_XFER_DONE = 6;
    localparam int unsigned FL_BUF_EMPTY = 5;
    localparam int unsigned FL_SEL_TRIG  = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL_A = 8'h00;
    localparam logic [7:0] RST_CONTROL_B = 8'h00;
    localparam logic [7:0] RST_INT_EN    = 8'h00;
    localparam logic [7:0] RST_INT_FLAGS = 8'h00;
    localparam logic [7:0] RST_DATA      = 8'h00;

    // ------------------------------------------------------------------
    // transfer modes and bus codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_RISE_SAMPLE = 2'h0;
    localparam logic [1:0] MODE_RISE_SETUP  = 2'h1;
    localparam logic [1:0] MODE_FALL_SAMPLE = 2'h2;
    localparam logic [1:0] MODE_FALL_SETUP  = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0] BIT_LAST         = 3'h7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 10000;
    localparam int unsigned EVT_MIN_PERIODS   = 2;
    localparam int unsigned EVT_MIN_CYC       = EVT_MIN_PERIODS;

    // ------------------------------------------------------------------
    // state of the main block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  control_a;
        logic [7:0]  control_b;
        logic [7:0]  int_en;
        logic [7:0]  flags;
        logic [7:0]  shift;
        logic [7:0]  tx_buf;
        logic        tx_full;
        logic        sh_full;
        logic [7:0]  rx_data;
        logic [2:0]  bit_cnt;
        logic        miso_bit;
        logic        sck_d;
        logic        sel_d;
        logic        done_d1;
        logic        done_d2;
        logic        dp_valid;
        logic        dp_write;
        logic        dp_hit;
        logic [2:0]  dp_idx;
        logic [31:0] rdata;
        logic        evt;
        logic        irq;
    } spcb_state_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } spcb_sync_t;

endpackage : spcb_pkg

// >>> rtl/spcb_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module spcb_sync
    import spcb_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    spcb_sync_t st_r;
    spcb_sync_t st_nxt;

    initial begin
        if (W < 1 || W > 8) begin
            $error("spcb_sync: width must be 1 to 8");
        end
    end

    // ------------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = '0;
        st_nxt.s2 = '0;
        st_nxt.s1[W-1:0] = d_in;
        st_nxt.s2[W-1:0] = st_r.s1[W-1:0];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            assign q_out[gi] = st_r.s2[gi];
        end
    endgenerate
endmodule : spcb_sync
`default_nettype wire

// >>> rtl/spcb_client.sv
// serial client with select handling, transmit buffer and register slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spcb_client
    import spcb_pkg::*;
#(
    parameter int unsigned DATA_W = 8
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    input  wire logic        SCK_IN,
    input  wire logic        MOSI_IN,
    input  wire logic        SEL_B_IN,
    input  wire logic        PORT_MISO_DIR_IN,
    output logic             MISO_OUT,
    output logic             MISO_OE_OUT,
    output logic             EVT_SCK_OUT,
    output logic             IRQ_OUT
);
    initial begin
        if (DATA_W != 8) begin
            $error("spcb_client: only byte transfers are supported");
        end
    end

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    logic [2:0] pins_s;
    spcb_sync #(.W(3)) u_sync (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (rst_n),
        .d_in     ({SEL_B_IN, MOSI_IN, SCK_IN}),
        .q_out    (pins_s)
    );
    logic sck_s;
    logic mosi_s;
    logic sel_b_s;
    assign sck_s   = pins_s[0];
    assign mosi_s  = pins_s[1];
    assign sel_b_s = pins_s[2];

    spcb_state_t st_r;
    spcb_state_t st_nxt;

    // ------------------------------------------------------------------
    // serial edge decode
    // ------------------------------------------------------------------
    logic       enabled;
    logic       buf_on;
    logic       wait_rcv;
    logic       lsb_first;
    logic [1:0] mode;
    logic       sel;
    logic       sel_fall;
    logic       rise;
    logic       fall;
    logic       sample_on_rise;
    logic       samp_e;
    logic       setup_e;
    logic       done;
    logic       tx_bit;
    logic [7:0] shifted;
    assign enabled   = st_r.control_a[CA_ENABLE];
    assign lsb_first = st_r.control_a[CA_LSB_FIRST];
    assign buf_on    = st_r.control_b[CB_BUF_ON];
    assign wait_rcv  = st_r.control_b[CB_WAIT_RCV];
    assign mode      = st_r.control_b[CB_MODE_LO +: 2];
    assign sel       = enabled & ~sel_b_s;
    assign sel_fall  = sel & ~st_r.sel_d;
    assign rise      = sck_s & ~st_r.sck_d;
    assign fall      = ~sck_s & st_r.sck_d;
    assign sample_on_rise = (mode == MODE_RISE_SAMPLE) || (mode == MODE_FALL_SETUP);
    assign samp_e    = sel & (sample_on_rise ? rise : fall);
    assign setup_e   = sel & (sample_on_rise ? fall : rise);
    assign done      = samp_e && (st_r.bit_cnt == BIT_LAST);
    assign tx_bit    = lsb_first ? st_r.shift[0] : st_r.shift[7];
    assign shifted   = lsb_first ? {mosi_s, st_r.shift[7:1]} : {st_r.shift[6:0], mosi_s};

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic       accept;
    logic       hit_a;
    logic       wr_now;
    logic [7:0] wbyte;
    logic       wr_data;
    logic       busy;
    assign accept  = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    assign hit_a   = (HADDR_IN[1:0] == 2'h0) && (HADDR_IN[31:5] == 27'h0)
                     && (32'(HADDR_IN[4:2]) <= IDX_LAST);
    assign wr_now  = st_r.dp_valid & st_r.dp_write & st_r.dp_hit;
    assign wbyte   = HWDATA_IN[7:0];
    assign wr_data = wr_now && (32'(st_r.dp_idx) == IDX_SERIAL_DATA);
    assign busy    = sel && ((st_r.bit_cnt != 3'h0) || samp_e);

    function automatic logic [7:0] eff_flags(input spcb_state_t s);
        logic [7:0] f;
        f = s.flags;
        f[FL_BUF_EMPTY] = s.control_b[CB_BUF_ON] & ~s.tx_full;
        return f;
    endfunction

    function automatic logic irq_of(input spcb_state_t s);
        logic [7:0] f;
        f = eff_flags(s);
        if (s.control_b[CB_BUF_ON]) begin
            return |(f[7:4] & s.int_en[7:4]);
        end
        return s.int_en[EN_SINGLE] & (f[FL_XFER] | f[FL_WRCOLL]);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] set_f;
        set_f = 8'h00;
        st_nxt = st_r;
        st_nxt.sck_d   = sck_s;
        st_nxt.sel_d   = sel;
        st_nxt.done_d1 = done & buf_on;
        // transfer complete only when no held byte was reloaded
        st_nxt.done_d2 = st_r.done_d1 & ~st_r.sh_full;
        st_nxt.evt     = sck_s;

        // serial engine
        if (!sel) begin
            st_nxt.bit_cnt = 3'h0;
            if (st_r.bit_cnt != 3'h0) begin
                st_nxt.sh_full = 1'b0;
            end
        end else if (samp_e) begin
            st_nxt.shift   = shifted;
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        end
        // leading edge decides setup in modes 1 and 3
        if (setup_e || (!mode[0] && st_r.bit_cnt == 3'h0)) begin
            st_nxt.miso_bit = tx_bit;
        end
        if (done) begin
            st_nxt.rx_data = shifted;
            st_nxt.sh_full = 1'b0;
            if (!buf_on) begin
                set_f[FL_XFER] = 1'b1;
            end else if (st_r.tx_full) begin
                st_nxt.shift   = st_r.tx_buf;
                st_nxt.tx_full = 1'b0;
                st_nxt.sh_full = 1'b1;
            end
        end
        // user data ready before first clock
        // only the first byte passes; later ones wait, else unsent data is lost
        if (buf_on && wait_rcv && sel_b_s && st_r.tx_full && !st_r.sh_full) begin
            st_nxt.shift   = st_r.tx_buf;
            st_nxt.tx_full = 1'b0;
            st_nxt.sh_full = 1'b1;
        end

        // flag pipeline shared by both wait settings
        if (buf_on) begin
            set_f[FL_SEL_TRIG] = sel_fall;
            set_f[FL_RCV_DONE] = st_r.done_d1;
            set_f[FL_XFER_DONE] = st_r.done_d2 & ~st_r.tx_full;
        end

        // register writes, data phase
        if (wr_now) begin
            case (st_r.dp_idx)
                3'(IDX_CONTROL_A):         st_nxt.control_a = wbyte;
                3'(IDX_CONTROL_B):         st_nxt.control_b = wbyte;
                3'(IDX_INTERRUPT_ENABLES): st_nxt.int_en = wbyte;
                // write one to clear; sets below win
                3'(IDX_INTERRUPT_FLAGS):   st_nxt.flags = st_r.flags & ~wbyte;
                default: ;
            endcase
        end
        if (wr_data) begin
            if (buf_on) begin
                if (!st_r.tx_full) begin
                    st_nxt.tx_buf  = wbyte;
                    st_nxt.tx_full = 1'b1;
                end
            end else if (busy) begin
                set_f[FL_WRCOLL] = 1'b1;
            end else begin
                st_nxt.shift = wbyte;
            end
        end
        st_nxt.flags = st_nxt.flags | set_f;
        st_nxt.flags[FL_BUF_EMPTY] = 1'b0;

        // address phase capture, read data registered for the data phase
        st_nxt.dp_valid = accept;
        st_nxt.dp_write = HWRITE_IN;
        st_nxt.dp_hit   = hit_a;
        st_nxt.dp_idx   = HADDR_IN[4:2];
        st_nxt.rdata    = 32'h0;
        if (accept && !HWRITE_IN && hit_a) begin
            case (HADDR_IN[4:2])
                3'(IDX_CONTROL_A):         st_nxt.rdata[7:0] = st_r.control_a;
                3'(IDX_CONTROL_B):         st_nxt.rdata[7:0] = st_r.control_b;
                3'(IDX_INTERRUPT_ENABLES): st_nxt.rdata[7:0] = st_r.int_en;
                3'(IDX_INTERRUPT_FLAGS):   st_nxt.rdata[7:0] = eff_flags(st_r);
                3'(IDX_SERIAL_DATA):       st_nxt.rdata[7:0] = st_r.rx_data;
                default:                   st_nxt.rdata = 32'h0;
            endcase
        end

        // one request line for both flag sets
        st_nxt.irq = irq_of(st_nxt);
    end

    always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.control_a <= RST_CONTROL_A;
            st_r.control_b <= RST_CONTROL_B;
            st_r.int_en    <= RST_INT_EN;
            st_r.flags     <= RST_INT_FLAGS;
            st_r.shift     <= RST_DATA;
            st_r.tx_buf    <= RST_DATA;
            st_r.rx_data   <= RST_DATA;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // zero wait states; every access answers okay
    assign HRDATA_OUT    = st_r.rdata;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;
    assign MISO_OUT      = st_r.miso_bit;
    // drive only when selected and direction is output
    assign MISO_OE_OUT   = st_r.sel_d & PORT_MISO_DIR_IN;
    // level event, host keeps levels above two periods
    assign EVT_SCK_OUT   = st_r.evt;
    assign IRQ_OUT       = st_r.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!rst_n);

    logic buf_wr_free;
    logic buf_wr_full;
    assign buf_wr_free = wr_data && buf_on && !st_r.tx_full;
    assign buf_wr_full = wr_data && buf_on && st_r.tx_full && !done;

    a_miso_oe_sel: assert property (sel_b_s |=> !MISO_OE_OUT)
        else $error("miso driven while deselected");
    a_cnt_clear: assert property (!sel |=> st_r.bit_cnt == 3'h0)
        else $error("bit counter not cleared by deselect");
    a_buf_take: assert property (buf_wr_free |=> st_r.tx_full && st_r.tx_buf == $past(wbyte))
        else $error("buffer write lost");
    a_buf_discard: assert property (buf_wr_full |=> $stable(st_r.tx_buf))
        else $error("full buffer overwritten");
    a_preload: assert property (buf_on && wait_rcv && sel_b_s && st_r.tx_full
        && !st_r.sh_full && !wr_now
        |=> !st_r.tx_full && st_r.shift == $past(st_r.tx_buf))
        else $error("held byte not preloaded");
    a_done_copy: assert property (done && buf_on && st_r.tx_full
        |=> st_r.shift == $past(st_r.tx_buf))
        else $error("held byte not copied at completion");
    a_rcv_flag: assert property (done && buf_on |-> ##2 st_r.flags[FL_RCV_DONE])
        else $error("receive flag not set two cycles after completion");
    a_irq_hold: assert property (IRQ_OUT && !wr_now |=> IRQ_OUT)
        else $error("interrupt dropped without a register write");
    a_write_collision_flag: assert property (wr_data && !buf_on && busy |=> st_r.flags[FL_WRCOLL])
        else $error("collision flag not set");
    a_byte_wrap: assert property (done |=> st_r.bit_cnt == 3'h0)
        else $error("counter did not wrap after eight bits");

    c_byte_done: cover property (done);
    c_sel_trig: cover property (buf_on && sel_fall);
    c_collision: cover property (wr_data && !buf_on && busy);
    c_preload: cover property (buf_on && wait_rcv && sel_b_s && st_r.tx_full && !st_r.sh_full);
endmodule : spcb_client
`default_nettype wire

// >>> bench/spcb_host.sv
// serial host model driving clock, select and host-out data line
`timescale 1ns/1ps
`default_nettype none
module spcb_host (
    input  wire logic miso_in,
    output var  logic sck_out,
    output var  logic mosi_out,
    output var  logic sel_b_out
);
    initial begin
        sck_out   = 1'b0;
        mosi_out  = 1'b1;
        sel_b_out = 1'b1;
    end

    // ------------------------------------------------------------------
    // clock parks at the mode's idle level between frames
    // ------------------------------------------------------------------
    task automatic park(input logic [1:0] mode);
        sck_out = mode[1];
    endtask : park

    // ------------------------------------------------------------------
    // one byte, msb first, cut short after nbits
    // ------------------------------------------------------------------
    task automatic xfer(input logic [1:0] mode, input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        park(mode);
        #80 sel_b_out = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            // setup and sample on opposite edges
            if (!mode[0]) mosi_out = tx[7-i];
            #80 sck_out = ~mode[1];
            if (mode[0]) mosi_out = tx[7-i];
            else rx = {rx[6:0], miso_in};
            #80 sck_out = mode[1];
            if (mode[0]) rx = {rx[6:0], miso_in};
        end
        // select may rise mid-byte, partial byte dropped
        #80 sel_b_out = 1'b1;
        // released line must not keep showing the last bit
        mosi_out = ~mosi_out;
    endtask : xfer
endmodule : spcb_host
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the serial client with select and transmit buffer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spcb_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        miso_dir;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        sck;
    logic        mosi;
    logic        sel_b;
    logic        miso;
    logic        oe;
    logic        evt;
    logic        irq;
    wire  logic  miso_w;
    int          err_count = 0;
    int          compares  = 0;

    // released pin shows the inverse, never a stale bit
    assign miso_w = oe ? miso : ~miso;

    spcb_client u_dut (
        .REF_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .SCK_IN(sck), .MOSI_IN(mosi), .SEL_B_IN(sel_b),
        .PORT_MISO_DIR_IN(miso_dir), .MISO_OUT(miso), .MISO_OE_OUT(oe),
        .EVT_SCK_OUT(evt), .IRQ_OUT(irq)
    );
    spcb_host u_host (.miso_in(miso_w), .sck_out(sck), .mosi_out(mosi), .sel_b_out(sel_b));

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input int unsigned idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= 32'(idx * 4);
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic wr(input int unsigned idx, input logic [7:0] d);
        logic [31:0] v;
        bus(1'b1, idx, d, v);
    endtask : wr
    task automatic rd(input int unsigned idx, output logic [31:0] v);
        bus(1'b0, idx, 8'h00, v);
    endtask : rd
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] v;
        wr(IDX_LAST + 1, 8'hff);
        for (int i = 0; i <= IDX_LAST + 1; i++) begin
            rd(i, v);
            chk(v, 32'h0);
        end
        $display("t_reset done");
    endtask : t_reset
    task automatic t_buffer(input logic [1:0] m);
        logic [31:0] v;
        logic [7:0]  rx;
        wr(IDX_INTERRUPT_FLAGS, 8'hff);
        wr(IDX_CONTROL_B, 8'hc0 | 8'(m));
        u_host.park(m);
        repeat (10) @(posedge clk);
        chk({31'h0, evt}, {31'h0, m[1]});
        wr(IDX_SERIAL_DATA, 8'h43);
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'h20, 32'h20);
        wr(IDX_SERIAL_DATA, 8'h44);
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'h20, 32'h0);
        wr(IDX_SERIAL_DATA, 8'h45);
        u_host.xfer(m, 8'ha5, 8, rx);
        chk({24'h0, rx}, 32'h43);
        rd(IDX_SERIAL_DATA, v);
        chk(v, 32'ha5);
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'hf0, 32'hb0);
        u_host.xfer(m, 8'h3c, 8, rx);
        chk({24'h0, rx}, 32'h44);
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'hc0, 32'hc0);
        $display("t_buffer mode %0d done", m);
    endtask : t_buffer
    task automatic t_irq();
        wr(IDX_INTERRUPT_ENABLES, 8'h80);
        irq_is(1'b1);
        wr(IDX_INTERRUPT_FLAGS, 8'h80);
        irq_is(1'b0);
        wr(IDX_INTERRUPT_ENABLES, 8'h40);
        irq_is(1'b1);
        wr(IDX_INTERRUPT_ENABLES, 8'h00);
        irq_is(1'b0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_abort();
        logic [31:0] v;
        logic [7:0]  rx;
        wr(IDX_CONTROL_B, 8'hc0);
        wr(IDX_INTERRUPT_FLAGS, 8'hff);
        wr(IDX_SERIAL_DATA, 8'h5a);
        @(posedge clk);
        miso_dir <= 1'b0;
        fork
            u_host.xfer(MODE_RISE_SAMPLE, 8'hff, 4, rx);
            #500 chk({31'h0, oe}, 32'h0);
        join
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'h80, 32'h0);
        miso_dir <= 1'b1;
        @(posedge clk);
        chk({31'h0, oe}, 32'h0);
        fork
            u_host.xfer(MODE_RISE_SAMPLE, 8'h96, 8, rx);
            #500 chk({31'h0, oe}, 32'h1);
        join
        rd(IDX_SERIAL_DATA, v);
        chk(v, 32'h96);
        $display("t_abort done");
    endtask : t_abort
    task automatic t_normal();
        logic [31:0] v;
        logic [7:0]  rx;
        wr(IDX_CONTROL_B, 8'h00);
        wr(IDX_INTERRUPT_FLAGS, 8'hff);
        wr(IDX_SERIAL_DATA, 8'h81);
        fork
            u_host.xfer(MODE_RISE_SAMPLE, 8'h18, 8, rx);
            #600 wr(IDX_SERIAL_DATA, 8'h7e);
        join
        chk({24'h0, rx}, 32'h81);
        rd(IDX_INTERRUPT_FLAGS, v);
        chk(v & 32'hc0, 32'hc0);
        wr(IDX_INTERRUPT_ENABLES, 8'h01);
        irq_is(1'b1);
        $display("t_normal done");
    endtask : t_normal

    // ------------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_b    = 1'b0;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hwdata   = 32'h0;
        miso_dir = 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        wr(IDX_CONTROL_A, 8'h01);
        // every transfer mode code in turn
        for (int m = 0; m < 4; m++) t_buffer(2'(m));
        t_irq();
        t_abort();
        t_normal();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
